// [rtl/sad_pkg.sv]
// package: windows, result types and constants of the system address decoder
package sad_pkg;

    // ==================================================
    // masters and transfer sizes
    localparam int         NUM_MST   = 3;
    localparam logic [1:0] MST_CORE  = 2'h0;
    localparam logic [1:0] MST_DMA   = 2'h1;
    localparam logic [1:0] MST_ETH   = 2'h2;
    localparam logic [2:0] SIZE_WORD = 3'h2;

    // ==================================================
    // address windows: base and offset mask
    localparam logic [31:0] FLASH_BASE   = 32'h0000_0000;
    localparam logic [31:0] FLASH_MASK   = 32'h0007_FFFF;
    localparam logic [31:0] VEC_MASK     = 32'h0000_003F;
    localparam logic [31:0] GPIO_BASE    = 32'h3FFF_C000;
    localparam logic [31:0] LSRAM_BASE   = 32'h4000_0000;
    localparam logic [31:0] LSRAM_MASK   = 32'h0000_FFFF;
    localparam logic [31:0] ETHRAM_BASE  = 32'h7FE0_0000;
    localparam logic [31:0] USBRAM_BASE  = 32'h7FD0_0000;
    localparam logic [31:0] SLOT_MASK    = 32'h0000_3FFF;
    localparam logic [31:0] STAT_BASE    = 32'h8000_0000;
    localparam logic [31:0] STAT_LAST    = 32'h83FF_FFFF;
    localparam logic [31:0] STAT_MASK    = 32'h00FF_FFFF;
    localparam logic [31:0] DYN_BASE     = 32'hA000_0000;
    localparam logic [31:0] DYN_LAST     = 32'hDFFF_FFFF;
    localparam logic [31:0] DYN_MASK     = 32'h0FFF_FFFF;
    localparam logic [31:0] APB_BASE     = 32'hE000_0000;
    localparam logic [31:0] APB_LAST     = 32'hEFFF_FFFF;
    localparam logic [31:0] PERI_MASK    = 32'h001F_FFFF;
    localparam logic [31:0] AHBP_BASE    = 32'hFFE0_0000;
    localparam int          APB_SLOTS    = 36;
    localparam int          SLOT_LSB     = 14;
    localparam int          SLOT_W       = 7;

    // ==================================================
    // types
    typedef enum logic [3:0] {
        RG_NONE, RG_FLASH, RG_GPIO, RG_LSRAM, RG_ETHRAM, RG_USBRAM,
        RG_STATIC, RG_DYNAMIC, RG_APB, RG_AHBP, RG_BOOTROM
    } sad_region_t;

    typedef enum logic [1:0] {
        SEG_NONE, SEG_LOCAL, SEG_PRIMARY, SEG_SECONDARY
    } sad_seg_t;

    typedef enum logic [1:0] {
        VEC_FLASH = 2'h0, VEC_BOOTROM = 2'h1, VEC_SRAM = 2'h2
    } sad_remap_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [2:0]  size;
        logic [31:0] addr;
    } sad_req_t;

    typedef struct packed {
        logic              valid;
        logic              error;
        logic              write;
        logic [2:0]        size;
        sad_region_t       region;
        sad_seg_t          seg;
        logic              bridged;
        logic [SLOT_W-1:0] slot;
        logic [31:0]       offset;
    } sad_resp_t;

    typedef struct packed {
        sad_resp_t [NUM_MST-1:0] resp;
    } sad_state_t;

endpackage : sad_pkg

// [rtl/sad_decoder.sv]
// module: system address decoder and master-to-segment steering
// Summary of operation
// - core byte order is always little-endian
// - secondary segment holds only Ethernet buffer SRAM
// - Ethernet reaches primary segment through bridge
// - primary segment serves core, DMA, bridged Ethernet
// - secondary segment serves only core and Ethernet
// - AHB peripherals: top 2 MB, 16 kB slots
// - APB peripherals: 2 MB at 3.5 GB
// - 0x0 to 0x7FFFF selects flash
// - 0x3FFFC000 to 0x3FFFFFFF selects fast GPIO
// - 0x40000000 to 0x4000FFFF selects local SRAM
// - local SRAM takes byte, halfword, word only
// - 0x7FE00000 to 0x7FE03FFF selects Ethernet SRAM
// - 0x7FD00000 to 0x7FD03FFF selects USB SRAM
// - four 16 MB static banks from 0x80000000
// - four 256 MB dynamic banks from 0xA0000000
// - APB area offers 36 slots of 16 kB
// - vector area remappable to flash, ROM, SRAM
module sad_decoder #(
    parameter int APB_SLOTS = sad_pkg::APB_SLOTS
) (
    // clock and reset
    input  logic                                      sys_clk,
    input  logic                                      resetn,
    // master requests: core, dma engine, ethernet
    input  sad_pkg::sad_req_t [sad_pkg::NUM_MST-1:0]  masterReq,
    // vector area source
    input  sad_pkg::sad_remap_t                       vecRemap,
    // decoded slave selection per master
    output sad_pkg::sad_resp_t [sad_pkg::NUM_MST-1:0] slaveSel,
    output logic                                      coreBigEndian
);

    // ==================================================
    // decode of one request
    localparam int                SLOT_W  = sad_pkg::SLOT_W;
    localparam logic [SLOT_W-1:0] APB_CNT = SLOT_W'(APB_SLOTS);

    // true when addr lies in the window base..base+mask
    function automatic logic inWin(
        input logic [31:0] a,
        input logic [31:0] base,
        input logic [31:0] mask);
        inWin = ((a & ~mask) == base);
    endfunction : inWin

    function automatic sad_pkg::sad_resp_t decode(
        input sad_pkg::sad_req_t   req,
        input logic [1:0]          mst,
        input sad_pkg::sad_remap_t remap);
        sad_pkg::sad_resp_t r;
        logic [31:0]        a;
        r        = '0;
        a        = req.addr;
        r.valid  = req.valid;
        r.write  = req.write;
        r.size   = req.size;
        r.region = sad_pkg::RG_NONE;
        r.seg    = sad_pkg::SEG_NONE;
        if (inWin(a, sad_pkg::FLASH_BASE, sad_pkg::FLASH_MASK)) begin
            r.region = sad_pkg::RG_FLASH;
            r.offset = a & sad_pkg::FLASH_MASK;
            // only the core fetches vectors, so only it sees the remap
            if (mst == sad_pkg::MST_CORE && inWin(a, 32'h0000_0000, sad_pkg::VEC_MASK)) begin
                case (remap)
                    sad_pkg::VEC_BOOTROM: r.region = sad_pkg::RG_BOOTROM;
                    sad_pkg::VEC_SRAM:    r.region = sad_pkg::RG_LSRAM;
                    default:              r.region = sad_pkg::RG_FLASH;
                endcase
            end
        end else if (inWin(a, sad_pkg::GPIO_BASE, sad_pkg::SLOT_MASK)) begin
            r.region = sad_pkg::RG_GPIO;
            r.offset = a & sad_pkg::SLOT_MASK;
        end else if (inWin(a, sad_pkg::LSRAM_BASE, sad_pkg::LSRAM_MASK)) begin
            r.region = sad_pkg::RG_LSRAM;
            r.offset = a & sad_pkg::LSRAM_MASK;
        end else if (inWin(a, sad_pkg::ETHRAM_BASE, sad_pkg::SLOT_MASK)) begin
            r.region = sad_pkg::RG_ETHRAM;
            r.offset = a & sad_pkg::SLOT_MASK;
        end else if (inWin(a, sad_pkg::USBRAM_BASE, sad_pkg::SLOT_MASK)) begin
            r.region = sad_pkg::RG_USBRAM;
            r.offset = a & sad_pkg::SLOT_MASK;
        end else if (a >= sad_pkg::STAT_BASE && a <= sad_pkg::STAT_LAST) begin
            r.region = sad_pkg::RG_STATIC;
            r.slot   = {5'h00, a[25:24]};
            r.offset = a & sad_pkg::STAT_MASK;
        end else if (a >= sad_pkg::DYN_BASE && a <= sad_pkg::DYN_LAST) begin
            // bank bits 29:28 run 2,3,0,1 across the four windows
            r.region = sad_pkg::RG_DYNAMIC;
            r.slot   = {5'h00, 2'(a[29:28] - 2'h2)};
            r.offset = a & sad_pkg::DYN_MASK;
        end else if (a >= sad_pkg::APB_BASE && a <= sad_pkg::APB_LAST) begin
            // only the low 2 MB and the populated slots answer
            if (a[27:21] == 7'h00 && a[20:14] < APB_CNT) begin
                r.region = sad_pkg::RG_APB;
                r.slot   = a[20:14];
                r.offset = a & sad_pkg::SLOT_MASK;
            end
        end else if (inWin(a, sad_pkg::AHBP_BASE, sad_pkg::PERI_MASK)) begin
            r.region = sad_pkg::RG_AHBP;
            r.slot   = a[20:14];
            r.offset = a & sad_pkg::SLOT_MASK;
        end
        // segment that carries the selected slave
        case (r.region)
            sad_pkg::RG_FLASH,
            sad_pkg::RG_GPIO,
            sad_pkg::RG_LSRAM,
            sad_pkg::RG_BOOTROM: r.seg = sad_pkg::SEG_LOCAL;
            sad_pkg::RG_ETHRAM:  r.seg = sad_pkg::SEG_SECONDARY;
            sad_pkg::RG_NONE:    r.seg = sad_pkg::SEG_NONE;
            default:             r.seg = sad_pkg::SEG_PRIMARY;
        endcase
        // the local bus belongs to the core alone
        if (mst != sad_pkg::MST_CORE && r.seg == sad_pkg::SEG_LOCAL) begin
            r.region = sad_pkg::RG_NONE;
        end
        // dma is no master on the secondary segment
        if (mst == sad_pkg::MST_DMA && r.seg == sad_pkg::SEG_SECONDARY) begin
            r.region = sad_pkg::RG_NONE;
        end
        // ethernet reaches primary slaves only over the bridge
        if (mst == sad_pkg::MST_ETH && r.seg == sad_pkg::SEG_PRIMARY) begin
            r.bridged = 1'b1;
        end
        // wider than a word is refused everywhere, local SRAM included
        if (req.size > sad_pkg::SIZE_WORD) begin
            r.region = sad_pkg::RG_NONE;
        end
        // an error selects nothing and drops the write strobe
        if (r.region == sad_pkg::RG_NONE) begin
            r.seg     = sad_pkg::SEG_NONE;
            r.slot    = '0;
            r.offset  = '0;
            r.bridged = 1'b0;
            r.write   = 1'b0;
            r.error   = req.valid;
        end
        if (!req.valid) begin
            r = '0;
        end
        return r;
    endfunction : decode

    // ==================================================
    // state
    sad_pkg::sad_state_t state_ff;
    sad_pkg::sad_state_t nxt_state;

    // one decode per master, all in parallel
    always_comb begin
        nxt_state = state_ff;
        for (int m = 0; m < sad_pkg::NUM_MST; m++) begin
            nxt_state.resp[m] = decode(masterReq[m], 2'(m), vecRemap);
        end
    end

    // registered so the select meets timing to far slaves
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign slaveSel      = state_ff.resp;
    assign coreBigEndian = 1'b0;

    // ==================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    chk_flash_select: assert property (
        masterReq[0].valid && masterReq[0].addr[31:19] == 13'h0000
        && masterReq[0].addr[18:6] != 13'h0000 && masterReq[0].size <= 3'h2
        |=> slaveSel[0].region == sad_pkg::RG_FLASH
        && slaveSel[0].offset == $past(masterReq[0].addr))
        else $error("flash window not selected");

    chk_gpio_select: assert property (
        masterReq[0].valid && masterReq[0].addr[31:14] == 18'h0FFFF && masterReq[0].size <= 3'h2
        |=> slaveSel[0].region == sad_pkg::RG_GPIO && slaveSel[0].seg == sad_pkg::SEG_LOCAL)
        else $error("fast gpio window not selected");

    chk_lsram_size: assert property (
        masterReq[0].valid && masterReq[0].addr[31:16] == 16'h4000
        |=> slaveSel[0].error == ($past(masterReq[0].size) > 3'h2))
        else $error("local sram size check wrong");

    chk_static_bank: assert property (
        masterReq[1].valid && masterReq[1].addr[31:26] == 6'h20 && masterReq[1].size <= 3'h2
        |=> slaveSel[1].region == sad_pkg::RG_STATIC
        && slaveSel[1].slot[1:0] == $past(masterReq[1].addr[25:24]))
        else $error("static bank index wrong");

    chk_dyn_bank: assert property (
        masterReq[1].valid && masterReq[1].addr[31:28] == 4'hC && masterReq[1].size <= 3'h2
        |=> slaveSel[1].region == sad_pkg::RG_DYNAMIC && slaveSel[1].slot == 7'h02)
        else $error("dynamic bank index wrong");

    chk_apb_slots: assert property (
        masterReq[2].valid && masterReq[2].addr[31:21] == 11'h700 && masterReq[2].addr[20:14] >= 7'h24
        |=> slaveSel[2].error && slaveSel[2].region == sad_pkg::RG_NONE)
        else $error("apb slot beyond count answered");

    chk_dma_no_net: assert property (
        masterReq[1].valid && masterReq[1].addr[31:14] == 18'h1FF80
        |=> slaveSel[1].error)
        else $error("dma reached secondary segment");

    chk_eth_bridge: assert property (
        slaveSel[2].seg == sad_pkg::SEG_PRIMARY |-> slaveSel[2].bridged
        ##1 (slaveSel[2].seg != sad_pkg::SEG_LOCAL))
        else $error("ethernet primary access not bridged");

    chk_vec_remap: assert property (
        masterReq[0].valid && masterReq[0].addr[31:6] == 26'h0 && masterReq[0].size <= 3'h2
        && vecRemap == sad_pkg::VEC_BOOTROM
        |=> slaveSel[0].region == sad_pkg::RG_BOOTROM)
        else $error("vector remap not applied");

    chk_error_quiet: assert property (
        slaveSel[0].error |-> !slaveSel[0].write && slaveSel[0].region == sad_pkg::RG_NONE
        && slaveSel[0].offset == 32'h0000_0000)
        else $error("errored access still selects");

    // ==================================================
    // window selection per region, one master each
    chk_lsram_select: assert property (
        masterReq[0].valid && masterReq[0].addr[31:16] == 16'h4000 && masterReq[0].size <= 3'h2
        |=> slaveSel[0].region == sad_pkg::RG_LSRAM && slaveSel[0].seg == sad_pkg::SEG_LOCAL
        && slaveSel[0].offset == {16'h0000, $past(masterReq[0].addr[15:0])})
        else $error("local sram window not selected");

    chk_ethram_select: assert property (
        masterReq[2].valid && masterReq[2].addr[31:14] == 18'h1FF80 && masterReq[2].size <= 3'h2
        |=> slaveSel[2].region == sad_pkg::RG_ETHRAM && !slaveSel[2].bridged
        && slaveSel[2].offset == {18'h00000, $past(masterReq[2].addr[13:0])})
        else $error("ethernet sram window not selected");

    chk_usbram_select: assert property (
        masterReq[1].valid && masterReq[1].addr[31:14] == 18'h1FF40 && masterReq[1].size <= 3'h2
        |=> slaveSel[1].region == sad_pkg::RG_USBRAM && slaveSel[1].seg == sad_pkg::SEG_PRIMARY
        && slaveSel[1].offset == {18'h00000, $past(masterReq[1].addr[13:0])})
        else $error("usb sram window not selected");

    chk_ahbp_slot: assert property (
        masterReq[0].valid && masterReq[0].addr[31:21] == 11'h7FF && masterReq[0].size <= 3'h2
        |=> slaveSel[0].region == sad_pkg::RG_AHBP && slaveSel[0].slot == $past(masterReq[0].addr[20:14])
        && slaveSel[0].offset == {18'h00000, $past(masterReq[0].addr[13:0])})
        else $error("ahb peripheral slot wrong");

    chk_apb_select: assert property (
        masterReq[0].valid && masterReq[0].addr[31:21] == 11'h700 && masterReq[0].addr[20:14] < 7'h24
        && masterReq[0].size <= 3'h2
        |=> slaveSel[0].region == sad_pkg::RG_APB && slaveSel[0].slot == $past(masterReq[0].addr[20:14]))
        else $error("apb slot not selected");

    chk_apb_window: assert property (
        masterReq[0].valid && masterReq[0].addr[31:28] == 4'hE && masterReq[0].addr[27:21] != 7'h00
        |=> slaveSel[0].error && slaveSel[0].region == sad_pkg::RG_NONE)
        else $error("apb access beyond 2 MB answered");

    chk_vec_sram: assert property (
        masterReq[0].valid && masterReq[0].addr[31:6] == 26'h0 && masterReq[0].size <= 3'h2
        && vecRemap == sad_pkg::VEC_SRAM
        |=> slaveSel[0].region == sad_pkg::RG_LSRAM && slaveSel[0].seg == sad_pkg::SEG_LOCAL)
        else $error("vector remap to sram not applied");

    chk_vec_default: assert property (
        masterReq[0].valid && masterReq[0].addr[31:6] == 26'h0 && masterReq[0].size <= 3'h2
        && vecRemap != sad_pkg::VEC_BOOTROM && vecRemap != sad_pkg::VEC_SRAM
        |=> slaveSel[0].region == sad_pkg::RG_FLASH)
        else $error("vectors not fetched from flash");

    // ==================================================
    // which master reaches which segment
    chk_core_net_seg: assert property (
        masterReq[0].valid && masterReq[0].addr[31:14] == 18'h1FF80 && masterReq[0].size <= 3'h2
        |=> slaveSel[0].region == sad_pkg::RG_ETHRAM && slaveSel[0].seg == sad_pkg::SEG_SECONDARY)
        else $error("core missed the secondary segment");

    chk_dma_no_local: assert property (
        masterReq[1].valid && masterReq[1].addr[31:19] == 13'h0000
        |=> slaveSel[1].error && slaveSel[1].seg == sad_pkg::SEG_NONE)
        else $error("dma reached the core local bus");

    chk_eth_no_local: assert property (
        masterReq[2].valid && masterReq[2].addr[31:16] == 16'h4000
        |=> slaveSel[2].error && slaveSel[2].seg == sad_pkg::SEG_NONE)
        else $error("ethernet reached the core local bus");

    chk_eth_to_static: assert property (
        masterReq[2].valid && masterReq[2].addr[31:26] == 6'h20 && masterReq[2].size <= 3'h2
        |=> slaveSel[2].region == sad_pkg::RG_STATIC && slaveSel[2].seg == sad_pkg::SEG_PRIMARY
        && slaveSel[2].bridged)
        else $error("ethernet buffer in static memory unreachable");

    chk_dma_not_bridged: assert property (
        slaveSel[1].valid |-> !slaveSel[1].bridged && slaveSel[1].seg != sad_pkg::SEG_LOCAL)
        else $error("dma answer marked as bridged");

    // ==================================================
    // refusals, idle answers and byte order
    chk_size_refused: assert property (
        masterReq[1].valid && masterReq[1].size > 3'h2
        |=> slaveSel[1].error && slaveSel[1].region == sad_pkg::RG_NONE && !slaveSel[1].write)
        else $error("transfer wider than a word accepted");

    chk_unmapped_error: assert property (
        masterReq[1].valid && masterReq[1].addr[31:28] == 4'hF && masterReq[1].addr[27:21] != 7'h7F
        |=> slaveSel[1].error && !slaveSel[1].write && slaveSel[1].seg == sad_pkg::SEG_NONE)
        else $error("unmapped access not refused");

    chk_idle_quiet: assert property (
        !masterReq[2].valid |=> slaveSel[2] == '0)
        else $error("idle master still selects");

    chk_byte_order: assert property (
        coreBigEndian == 1'b0)
        else $error("core byte order not little-endian");

endmodule : sad_decoder

// [dv/sad_master_model.sv]
// bus master model: core, dma engine and ethernet requesters
module sad_master_model (
    // request outputs, one per master
    output sad_pkg::sad_req_t [sad_pkg::NUM_MST-1:0] masterReq
);
    timeunit 1ns;
    timeprecision 1ns;
    initial masterReq = '0;
    // an idle master scrambles its address so stale values never look like a request
    task automatic drive(input int m, input sad_pkg::sad_req_t q);
        if (!q.valid) begin
            q.addr = ~masterReq[m].addr;
        end
        masterReq[m] = q;
    endtask : drive
endmodule : sad_master_model

// [dv/system_address_decoder_tb.sv]
// testbench: decoder against a behavioural address map
module system_address_decoder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    sad_pkg::sad_req_t [2:0] masterReq;
    sad_pkg::sad_remap_t vecRemap = sad_pkg::VEC_FLASH;
    sad_pkg::sad_resp_t [2:0] slaveSel;
    sad_pkg::sad_resp_t [2:0] expResp = '0;
    logic coreBigEndian;
    int numErrors = 0;
    int checksDone = 0;
    logic [31:0] edges[24] = '{32'h3F, 32'h40, 32'h7_FFFF, 32'h8_0000, 32'h3FFF_BFFF, 32'h3FFF_C000,
        32'h4000_FFFF, 32'h4001_0000, 32'h7FE0_3FFF, 32'h7FE0_4000, 32'h7FD0_3FFF, 32'h7FCF_FFFF,
        32'h80FF_FFFC, 32'h83FF_FFFF, 32'h8400_0000, 32'h9FFF_FFFF, 32'hA000_0000, 32'hDFFF_FFFF,
        32'hE008_FFFF, 32'hE009_0000, 32'hE020_0000, 32'hEFFF_FFFF, 32'hFFDF_FFFF, 32'hFFFF_FFFF};
    logic [31:0] bases[10] = '{32'h0, 32'h3FFF_C000, 32'h4000_0000, 32'h7FE0_0000, 32'h7FD0_0000,
        32'h8000_0000, 32'hA000_0000, 32'hE000_0000, 32'hFFE0_0000, 32'hF000_0000};
    // 20 MHz system clock
    always #25 sys_clk = ~sys_clk;
    sad_master_model i_sad_master_model (.masterReq(masterReq));
    sad_decoder i_sad_decoder (.sys_clk(sys_clk), .resetn(resetn), .masterReq(masterReq),
        .vecRemap(vecRemap), .slaveSel(slaveSel), .coreBigEndian(coreBigEndian));
    // reference map, written with plain integers
    function automatic sad_pkg::sad_resp_t model(input sad_pkg::sad_req_t q, input int m,
                                                 input sad_pkg::sad_remap_t rm);
        sad_pkg::sad_resp_t r;
        longint a;
        bit bad;
        r = '0;
        a = q.addr;
        if (!q.valid) return r;
        r.valid = 1;
        r.write = q.write;
        r.size = q.size;
        bad = q.size > 2;
        r.seg = sad_pkg::SEG_PRIMARY;
        r.bridged = (m == 2);
        r.offset = 32'(a & 'h3FFF);
        r.slot = 7'((a >> 14) & 'h7F);
        if (a <= 'h3F && m == 0 && rm == sad_pkg::VEC_BOOTROM) r.region = sad_pkg::RG_BOOTROM;
        else if (a <= 'h3F && m == 0 && rm == sad_pkg::VEC_SRAM) r.region = sad_pkg::RG_LSRAM;
        else if (a <= 'h7FFFF) r.region = sad_pkg::RG_FLASH;
        else if (a >= 'h3FFFC000 && a <= 'h3FFFFFFF) r.region = sad_pkg::RG_GPIO;
        else if (a >= 'h40000000 && a <= 'h4000FFFF) r.region = sad_pkg::RG_LSRAM;
        else if (a >= 'h7FE00000 && a <= 'h7FE03FFF) r.region = sad_pkg::RG_ETHRAM;
        else if (a >= 'h7FD00000 && a <= 'h7FD03FFF) r.region = sad_pkg::RG_USBRAM;
        else if (a >= 'h80000000 && a <= 'h83FFFFFF) r.region = sad_pkg::RG_STATIC;
        else if (a >= 'hA0000000 && a <= 'hDFFFFFFF) r.region = sad_pkg::RG_DYNAMIC;
        else if (a >= 'hE0000000 && a <= 'hEFFFFFFF) r.region = sad_pkg::RG_APB;
        else if (a >= 'hFFE00000) r.region = sad_pkg::RG_AHBP;
        else bad = 1;
        case (r.region)
            sad_pkg::RG_FLASH, sad_pkg::RG_GPIO, sad_pkg::RG_LSRAM, sad_pkg::RG_BOOTROM: begin
                r.seg = sad_pkg::SEG_LOCAL;
                r.bridged = 0;
                bad |= m != 0;
                r.offset = (a <= 'h7FFFF) ? 32'(a) : 32'(a & (r.region == sad_pkg::RG_GPIO ? 'h3FFF : 'hFFFF));
            end
            sad_pkg::RG_ETHRAM: begin
                r.seg = sad_pkg::SEG_SECONDARY;
                r.bridged = 0;
                bad |= m == 1;
            end
            sad_pkg::RG_STATIC: begin
                r.slot = 7'((a >> 24) & 3);
                r.offset = 32'(a & 'hFFFFFF);
            end
            sad_pkg::RG_DYNAMIC: begin
                r.slot = 7'((a >> 28) - 10);
                r.offset = 32'(a & 'hFFFFFFF);
            end
            sad_pkg::RG_APB: bad |= (a & 'hFFFFFFF) >= 'h200000 || r.slot >= 36;
            default: ;
        endcase
        // only banked and slotted regions carry a slot number
        if (!(r.region inside {sad_pkg::RG_STATIC, sad_pkg::RG_DYNAMIC, sad_pkg::RG_APB, sad_pkg::RG_AHBP}))
            r.slot = 7'h00;
        if (bad) begin
            r = '0;
            r.valid = 1;
            r.error = 1;
            r.size = q.size;
        end
        return r;
    endfunction : model
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checksDone++;
        if (seen !== exp) begin
            numErrors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // compare last answer, then present a fresh set of requests
    task automatic cycle(input logic [31:0] fix, input bit useFix);
        sad_pkg::sad_req_t q;
        @(negedge sys_clk);
        for (int m = 0; m < 3; m++) check("slaveSel", 64'(slaveSel[m]), 64'(expResp[m]));
        check("coreBigEndian", 64'(coreBigEndian), 64'h0);
        vecRemap = sad_pkg::sad_remap_t'($urandom_range(3, 0));
        for (int m = 0; m < 3; m++) begin
            q.valid = $urandom_range(7, 0) != 0;
            q.write = 1'($urandom);
            q.size = ($urandom_range(5, 0) == 5) ? 3'h3 : 3'($urandom_range(2, 0));
            q.addr = useFix ? fix : (($urandom_range(3, 0) == 0) ? $urandom
                     : bases[$urandom_range(9, 0)] + ($urandom & 32'h1F_FFFF));
            if (!useFix && bases[6] == q.addr - (q.addr & 32'h1F_FFFF) && $urandom_range(1, 0)) q.addr += 32'h1000_0000;
            i_sad_master_model.drive(m, q);
            expResp[m] = model(q, m, vecRemap);
        end
    endtask : cycle
    task automatic hit_reset();
        sad_pkg::sad_req_t idle;
        idle = '0;
        @(negedge sys_clk);
        for (int m = 0; m < 3; m++) check("slaveSel", 64'(slaveSel[m]), 64'(expResp[m]));
        resetn = 1'b0;
        for (int m = 0; m < 3; m++) i_sad_master_model.drive(m, idle);
        #1;
        for (int m = 0; m < 3; m++) check("slaveSel", 64'(slaveSel[m]), 64'h0);
        expResp = '0;
        repeat (3) @(negedge sys_clk);
        resetn = 1'b1;
    endtask : hit_reset
    task automatic stopTest();
        if (numErrors == 0 && checksDone > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stopTest
    initial begin
        #500000;
        numErrors++;
        stopTest();
    end
    initial begin
        void'($urandom(46730));
        repeat (3) @(negedge sys_clk);
        resetn = 1'b1;
        foreach (edges[i]) repeat (4) cycle(edges[i], 1'b1);
        repeat (1500) cycle('0, 1'b0);
        hit_reset();
        repeat (1500) cycle('0, 1'b0);
        cycle('0, 1'b0);
        stopTest();
    end
endmodule : system_address_decoder_tb
